// file: core/spec_consts.svh
`ifndef SPEC_CONSTS_SVH
`define SPEC_CONSTS_SVH

// timing
`define SPEC_CLK_PERIOD_NS 25
`define SPEC_NS_PER_MS     1000000
`define SPEC_CAL_MS        4
`define SPEC_PRESC_W       24
`define SPEC_CAL_W         8
`define SPEC_PERIOD_W      16
`define SPEC_PERIOD_MIN    16'h0001

// power-mode selection field encoding
`define SPEC_SEL_W         3
`define SPEC_SEL_FAST      3'h0
`define SPEC_SEL_NORMAL    3'h1
`define SPEC_SEL_SLOW      3'h2
`define SPEC_SEL_SLEEP     3'h3
`define SPEC_SEL_HALT      3'h4
`define SPEC_SEL_AUTO      3'h5

// event flag / mask bit positions
`define SPEC_EV_W          5
`define SPEC_EV_PWR        0
`define SPEC_EV_CAL        1
`define SPEC_EV_TOUCH      2
`define SPEC_EV_PROX       3
`define SPEC_EV_HALL       4

// core oscillator choice
`define SPEC_OSC_14MHZ     1'b0
`define SPEC_OSC_18MHZ     1'b1

`endif

// file: core/spec_ctrl.sv
`include "spec_consts.svh"

// How it works
// [R1] with auto recalibration enabled, Hall encoder recalibrates itself when needed
// [R2] comms-during-calibration set keeps windows opening while calibration runs
// [R3] warm reset command returns the block to its reset state
// [R4] automatic switching enters touch-only sleep only while its enable is set
// [R5] touch-only sleep samples the touch channel only, no Hall measurements
// [R6] oscillator select picks 14 MHz or 18 MHz, on one variant only
// [R7] fast-track has the fastest rate and is used while rotation occurs
// [R8] normal rate is used during touch and right after fast-track ends
// [R9] slow rate saves power, lowest mode still sampling Hall channels
// [R10] halt senses nothing at all
// [R11] halt is left only on a host force-communication request
// [R12] automatic setting switches modes from touch and Hall events
// [R13] automatic switching never enters halt
// [R14] each mode has its own report period in ms; each cycle measures all active channels
// [R15] host keeps fast-track period below normal, normal below slow
// [R16] masked events open no event-mode window
// [R17] mask gates windows only; flags set regardless
// [R18] separate masks for power-mode, calibration, touch, proximity, Hall interval events
// [R19] streaming after power-on until reset flag acknowledged, then event mode
// [R20] streaming opens a window after every cycle, event mode only on events
// [R21] automatic drop to low power only while Hall stationary flag is set
// [R22] power-mode event flag set on every mode change; a warm reset changes the mode with all flags cleared instead
// [R23] selection field: 0 fast, 1 normal, 2 slow, 3 sleep, 4 halt, 5 auto
module spec_ctrl #(
  parameter int unsigned CYCLES_PER_MS  = `SPEC_NS_PER_MS / `SPEC_CLK_PERIOD_NS,
  parameter int unsigned CAL_MS         = `SPEC_CAL_MS,
  parameter bit          HAS_OSC_SELECT = 1'b1
) (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_i,
  // link pins
  input  wire logic                      link_clk_i,
  input  wire logic                      link_data_i,
  // configuration
  input  wire logic [`SPEC_SEL_W-1:0]    power_mode_sel_i,
  input  wire logic [`SPEC_PERIOD_W-1:0] fast_period_ms_i,
  input  wire logic [`SPEC_PERIOD_W-1:0] normal_period_ms_i,
  input  wire logic [`SPEC_PERIOD_W-1:0] slow_period_ms_i,
  input  wire logic [`SPEC_PERIOD_W-1:0] sleep_period_ms_i,
  input  wire logic                      hall_auto_recal_enable_i,
  input  wire logic                      comms_during_calibration_i,
  input  wire logic                      touch_only_sleep_enable_i,
  input  wire logic                      core_oscillator_select_i,
  input  wire logic                      event_mode_i,
  input  wire logic                      streaming_enable_i,
  input  wire logic [`SPEC_EV_W-1:0]     event_mask_i,
  // commands, one-cycle pulses
  input  wire logic                      warm_reset_cmd_i,
  input  wire logic                      ack_reset_i,
  input  wire logic                      force_calibration_i,
  // sensor front-end status
  input  wire logic                      rotation_i,
  input  wire logic                      touch_state_i,
  input  wire logic                      prox_state_i,
  input  wire logic                      hall_stationary_i,
  input  wire logic                      touch_dormant_i,
  input  wire logic                      hall_interval_change_i,
  input  wire logic                      hall_recal_needed_i,
  // outputs
  output logic [2:0]                     power_mode_o,
  output logic [1:0]                     comm_mode_o,
  output logic                           hall_measure_o,
  output logic                           touch_measure_o,
  output logic                           comm_window_o,
  output logic [`SPEC_EV_W-1:0]          event_flags_o,
  output logic                           reset_flag_o,
  output logic                           calibration_active_o,
  output logic                           core_oscillator_select_o,
  output logic                           warm_reset_o
);

  // terminal counts are kept one below the length
  // so a compare against the counter ends the span
  localparam logic [`SPEC_PRESC_W-1:0] MS_LAST  = `SPEC_PRESC_W'(CYCLES_PER_MS - 1);
  localparam logic [`SPEC_CAL_W-1:0]   CAL_LAST = `SPEC_CAL_W'(CAL_MS - 1);

  // reset image, loaded again by a warm reset
  // power-on starts at normal rate and streaming
  // oscillator defaults to the faster clock
  localparam spec_pkg::spec_state_t RST = '{
    pmode:      spec_pkg::pm_normal,
    comm:       spec_pkg::cm_stream,
    sel_prev:   `SPEC_SEL_NORMAL,
    ms_cnt:     '0,
    period_cnt: '0,
    flags:      '0,
    cal_cnt:    '0,
    reset_flag: 1'b1,
    window:     1'b0,
    cal_active: 1'b0,
    touch_q:    1'b0,
    prox_q:     1'b0,
    hall_meas:  1'b0,
    touch_meas: 1'b0,
    warm_pulse: 1'b0,
    osc_sel:    `SPEC_OSC_18MHZ
  };

  spec_pkg::spec_state_t s_r;
  spec_pkg::spec_state_t s_nxt;

  // helpers of the next-state process
  logic                      start_pulse;
  logic                      stop_pulse;
  logic                      ms_tick;
  logic                      cycle_end;
  logic                      cal_done;
  logic                      blocked;
  logic                      open_req;
  logic                      win_close;
  logic [`SPEC_PERIOD_W-1:0] period;
  logic [`SPEC_EV_W-1:0]     ev_set;
  spec_pkg::spec_pmode_t     pm_nxt;
  spec_pkg::spec_comm_t      comm_nxt;

  // link pins are asynchronous; only start and stop are used
  // a start doubles as the host's force-communication request
  spec_link_sync u_link_sync (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .link_clk_i  (link_clk_i),
    .link_data_i (link_data_i),
    .start_o     (start_pulse),
    .stop_o      (stop_pulse)
  );

  // Hall plates are measured in fast, normal and slow modes only
  function automatic logic hall_active(input spec_pkg::spec_pmode_t pm);
    hall_active = (pm == spec_pkg::pm_fast) || (pm == spec_pkg::pm_normal) ||
                  (pm == spec_pkg::pm_slow);
  endfunction

  // explicit selections only; auto codes never reach here
  // only the normal code takes the default arm
  function automatic spec_pkg::spec_pmode_t sel_to_mode(input logic [`SPEC_SEL_W-1:0] sel);
    unique case (sel)
      `SPEC_SEL_FAST:   sel_to_mode = spec_pkg::pm_fast;
      `SPEC_SEL_SLOW:   sel_to_mode = spec_pkg::pm_slow;
      `SPEC_SEL_SLEEP:  sel_to_mode = spec_pkg::pm_sleep;
      `SPEC_SEL_HALT:   sel_to_mode = spec_pkg::pm_halt;
      default:          sel_to_mode = spec_pkg::pm_normal;
    endcase
  endfunction

  always_comb begin
    s_nxt            = s_r;
    s_nxt.hall_meas  = 1'b0;
    s_nxt.touch_meas = 1'b0;
    s_nxt.warm_pulse = 1'b0;
    s_nxt.sel_prev   = power_mode_sel_i;
    s_nxt.osc_sel    = HAS_OSC_SELECT ? core_oscillator_select_i : `SPEC_OSC_18MHZ; // [R6]

    // millisecond prescaler
    // one tick per ms keeps the period counters narrow
    ms_tick      = (s_r.ms_cnt == MS_LAST);
    s_nxt.ms_cnt = ms_tick ? '0 : s_r.ms_cnt + 1'b1;

    // report period of the current mode
    unique case (s_r.pmode)
      spec_pkg::pm_fast:  period = fast_period_ms_i; // [R14]
      spec_pkg::pm_slow:  period = slow_period_ms_i;
      spec_pkg::pm_sleep: period = sleep_period_ms_i;
      default:            period = normal_period_ms_i;
    endcase
    // a zero period would stall the timer
    if (period == '0) begin
      period = `SPEC_PERIOD_MIN;
    end

    // measurement cycle timer; halt runs no cycles
    // touch is sampled in every running mode
    // hall only where the plates are powered
    cycle_end = 1'b0;
    if (s_r.pmode != spec_pkg::pm_halt && ms_tick) begin // [R10]
      if (s_r.period_cnt >= period - `SPEC_PERIOD_MIN) begin
        cycle_end          = 1'b1;
        s_nxt.period_cnt   = '0;
        s_nxt.touch_meas   = 1'b1; // [R14]
        s_nxt.hall_meas    = hall_active(s_r.pmode); // [R5] [R9]
      end else begin
        s_nxt.period_cnt = s_r.period_cnt + 1'b1;
      end
    end

    // calibration routine, timed in ms so it also ends outside sensing modes
    // requests while busy are dropped, not queued
    // auto recalibration only where hall is measured
    cal_done = 1'b0;
    if (s_r.cal_active) begin
      if (ms_tick) begin
        if (s_r.cal_cnt == CAL_LAST) begin
          cal_done         = 1'b1;
          s_nxt.cal_active = 1'b0;
          s_nxt.cal_cnt    = '0;
        end else begin
          s_nxt.cal_cnt = s_r.cal_cnt + 1'b1;
        end
      end
    end else if (force_calibration_i ||
                 (hall_auto_recal_enable_i && hall_recal_needed_i && hall_active(s_r.pmode))) begin // [R1]
      s_nxt.cal_active = 1'b1;
      s_nxt.cal_cnt    = '0;
    end

    // power-mode machine
    // codes above auto act as auto
    // auto never picks halt; only a fresh halt selection does
    // every route out of halt except a warm reset needs a link start
    pm_nxt = s_r.pmode;
    if (power_mode_sel_i == `SPEC_SEL_AUTO || power_mode_sel_i > `SPEC_SEL_AUTO) begin // [R12] [R23]
      unique case (s_r.pmode)
        spec_pkg::pm_fast: begin
          if (!rotation_i) begin
            pm_nxt = spec_pkg::pm_normal; // [R8]
          end
        end
        spec_pkg::pm_normal: begin
          if (rotation_i) begin
            pm_nxt = spec_pkg::pm_fast; // [R7]
          end else if (!touch_state_i && !prox_state_i && hall_stationary_i && touch_dormant_i) begin
            pm_nxt = spec_pkg::pm_slow; // [R21]
          end
        end
        spec_pkg::pm_slow: begin
          if (rotation_i) begin
            pm_nxt = spec_pkg::pm_fast; // [R7]
          end else if (touch_state_i || prox_state_i || !hall_stationary_i) begin
            pm_nxt = spec_pkg::pm_normal; // [R8]
          end else if (touch_only_sleep_enable_i && touch_dormant_i) begin
            pm_nxt = spec_pkg::pm_sleep; // [R4]
          end
        end
        spec_pkg::pm_sleep: begin
          // rotation is invisible here; touch or proximity wakes it, clearing the sleep enable drops it to slow
          if (touch_state_i || prox_state_i) begin
            pm_nxt = spec_pkg::pm_normal; // [R5] [R8]
          end else if (!touch_only_sleep_enable_i) begin
            pm_nxt = spec_pkg::pm_slow; // [R4]
          end
        end
        spec_pkg::pm_halt: begin
          // automatic switching never enters halt; a halted device waits for the host
          if (start_pulse) begin
            pm_nxt = spec_pkg::pm_normal; // [R11] [R13]
          end
        end
      endcase
    end else if (power_mode_sel_i == `SPEC_SEL_HALT) begin
      // halt only on a fresh explicit selection, so a woken device stays awake
      if (s_r.pmode == spec_pkg::pm_halt) begin
        if (start_pulse) begin
          pm_nxt = spec_pkg::pm_normal; // [R11]
        end
      end else if (s_r.sel_prev != `SPEC_SEL_HALT) begin
        pm_nxt = spec_pkg::pm_halt; // [R10] [R13]
      end
    end else if (s_r.pmode != spec_pkg::pm_halt || start_pulse) begin
      pm_nxt = sel_to_mode(power_mode_sel_i); // [R11] [R23]
    end
    s_nxt.pmode = pm_nxt;
    if (pm_nxt != s_r.pmode) begin
      // new rate starts a fresh cycle
      s_nxt.period_cnt = '0;
    end

    // events
    // flags are set whether masked or not
    // touch and prox edges are ignored while halted
    ev_set                   = '0;
    ev_set[`SPEC_EV_PWR]     = (pm_nxt != s_r.pmode); // [R22]
    ev_set[`SPEC_EV_CAL]     = cal_done;
    ev_set[`SPEC_EV_TOUCH]   = (s_r.pmode != spec_pkg::pm_halt) && (touch_state_i != s_r.touch_q);
    ev_set[`SPEC_EV_PROX]    = (s_r.pmode != spec_pkg::pm_halt) && (prox_state_i != s_r.prox_q);
    ev_set[`SPEC_EV_HALL]    = hall_interval_change_i && hall_active(s_r.pmode); // [R5]
    if (s_r.pmode != spec_pkg::pm_halt) begin
      s_nxt.touch_q = touch_state_i;
      s_nxt.prox_q  = prox_state_i;
    end

    // reset flag and communication mode
    // streaming is forced until the host acknowledges
    // the mode follows the flag one cycle later
    if (ack_reset_i) begin
      s_nxt.reset_flag = 1'b0;
    end
    if (s_r.reset_flag) begin
      comm_nxt = spec_pkg::cm_stream; // [R19]
    end else if (event_mode_i) begin
      comm_nxt = spec_pkg::cm_event; // [R19]
    end else if (streaming_enable_i) begin
      comm_nxt = spec_pkg::cm_stream;
    end else begin
      comm_nxt = spec_pkg::cm_standalone;
    end
    s_nxt.comm = comm_nxt;

    // communication window
    // a start always opens, even while calibrating
    // close wins over open in the same cycle
    blocked   = s_r.cal_active && !comms_during_calibration_i; // [R2]
    open_req  = start_pulse ||
                (!blocked && s_r.comm == spec_pkg::cm_stream && cycle_end) || // [R20]
                (!blocked && s_r.comm == spec_pkg::cm_event &&
                 ((s_r.flags & event_mask_i) != '0)); // [R16] [R18] [R20]
    win_close = s_r.window && stop_pulse;
    if (win_close) begin
      s_nxt.window = 1'b0;
    end else if (open_req) begin
      s_nxt.window = 1'b1;
    end

    // flags cleared by the read that closes the window; a new event still lands
    s_nxt.flags = (win_close ? '0 : s_r.flags) | ev_set; // [R17]

    // warm reset overrides everything
    if (warm_reset_cmd_i) begin
      s_nxt            = RST; // [R3]
      s_nxt.warm_pulse = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // every output comes straight from the state register
  assign power_mode_o             = s_r.pmode;
  assign comm_mode_o              = s_r.comm;
  assign hall_measure_o           = s_r.hall_meas;
  assign touch_measure_o          = s_r.touch_meas;
  assign comm_window_o            = s_r.window;
  assign event_flags_o            = s_r.flags;
  assign reset_flag_o             = s_r.reset_flag;
  assign calibration_active_o     = s_r.cal_active;
  assign core_oscillator_select_o = s_r.osc_sel;
  assign warm_reset_o             = s_r.warm_pulse;

endmodule

// file: core/spec_link_sync.sv
`include "spec_consts.svh"

// brings the link clock and data pins into sys_clk_i and finds start/stop conditions
module spec_link_sync (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic link_clk_i,
  input  wire logic link_data_i,
  output logic      start_o,
  output logic      stop_o
);

  spec_pkg::spec_sync_t s_r;
  spec_pkg::spec_sync_t s_nxt;

  always_comb begin
    s_nxt          = s_r;
    s_nxt.scl_meta = link_clk_i;
    s_nxt.sda_meta = link_data_i;
    s_nxt.scl_s    = s_r.scl_meta;
    s_nxt.sda_s    = s_r.sda_meta;
    s_nxt.scl_d    = s_r.scl_s;
    s_nxt.sda_d    = s_r.sda_s;
    // data falling while clock stays high
    s_nxt.start    = s_r.scl_s & s_r.scl_d & s_r.sda_d & ~s_r.sda_s;
    // data rising while clock stays high
    s_nxt.stop     = s_r.scl_s & s_r.scl_d & ~s_r.sda_d & s_r.sda_s;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      // idle bus is high on both lines; avoids a false start at release
      s_r <= '{scl_meta: 1'b1, sda_meta: 1'b1, scl_s: 1'b1, sda_s: 1'b1,
               scl_d: 1'b1, sda_d: 1'b1, start: 1'b0, stop: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign start_o = s_r.start;
  assign stop_o  = s_r.stop;

endmodule

// file: core/spec_pkg.sv
`include "spec_consts.svh"

package spec_pkg;

  typedef enum logic [2:0] {
    pm_fast,
    pm_normal,
    pm_slow,
    pm_sleep,
    pm_halt
  } spec_pmode_t;

  typedef enum logic [1:0] {
    cm_stream,
    cm_event,
    cm_standalone
  } spec_comm_t;

  typedef struct packed {
    logic scl_meta;
    logic sda_meta;
    logic scl_s;
    logic sda_s;
    logic scl_d;
    logic sda_d;
    logic start;
    logic stop;
  } spec_sync_t;

  typedef struct packed {
    spec_pmode_t                pmode;
    spec_comm_t                 comm;
    logic [`SPEC_SEL_W-1:0]     sel_prev;
    logic [`SPEC_PRESC_W-1:0]   ms_cnt;
    logic [`SPEC_PERIOD_W-1:0]  period_cnt;
    logic [`SPEC_EV_W-1:0]      flags;
    logic [`SPEC_CAL_W-1:0]     cal_cnt;
    logic                       reset_flag;
    logic                       window;
    logic                       cal_active;
    logic                       touch_q;
    logic                       prox_q;
    logic                       hall_meas;
    logic                       touch_meas;
    logic                       warm_pulse;
    logic                       osc_sel;
  } spec_state_t;

endpackage

// file: verification/spec_chk.sv
module spec_chk (
  input logic       sys_clk_i,
  input logic       rst_i,
  input logic       link_clk_i,
  input logic       link_data_i,
  input logic [2:0] power_mode_sel_i,
  input logic       touch_only_sleep_enable_i,
  input logic       hall_auto_recal_enable_i,
  input logic       comms_during_calibration_i,
  input logic       force_calibration_i,
  input logic       warm_reset_cmd_i,
  input logic       touch_state_i,
  input logic [4:0] event_mask_i,
  input logic [2:0] power_mode_o,
  input logic [1:0] comm_mode_o,
  input logic       hall_measure_o,
  input logic       touch_measure_o,
  input logic       comm_window_o,
  input logic [4:0] event_flags_o,
  input logic       reset_flag_o,
  input logic       calibration_active_o,
  input logic       warm_reset_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  // no start can still be in the pin synchroniser after this
  sequence link_quiet;
    (link_clk_i && link_data_i) [*6];
  endsequence

  // the edge that enters a mode may still carry the last pulse of the old one
  a_halt_no_sense: assert property (
    $stable(power_mode_o) && power_mode_o == 3'h4 |-> !hall_measure_o && !touch_measure_o)
    else $error("measurement pulse while halted");
  a_sleep_no_hall: assert property (
    $stable(power_mode_o) && power_mode_o == 3'h3 |-> !hall_measure_o)
    else $error("hall pulse in touch-only sleep");
  a_auto_no_halt: assert property (
    power_mode_sel_i != 3'h4 && power_mode_o != 3'h4 |=> power_mode_o != 3'h4)
    else $error("halt entered without selection");
  a_sleep_gated: assert property (
    power_mode_sel_i >= 3'h5 && !touch_only_sleep_enable_i && power_mode_o != 3'h3 |=> power_mode_o != 3'h3)
    else $error("auto entered sleep while disabled");
  a_mode_flag: assert property (
    $changed(power_mode_o) && !warm_reset_o |-> ##[0:1] event_flags_o[0])
    else $error("mode change without flag");
  a_mask_no_window: assert property (
    link_quiet ##0 (comm_mode_o == 2'h1 && event_mask_i == 5'h00 && !comm_window_o) |=> !comm_window_o)
    else $error("window opened with all events masked");
  a_flag_unmasked: assert property (
    $rose(touch_state_i) && power_mode_o != 3'h4 |-> ##[1:3] event_flags_o[2])
    else $error("touch flag not set");
  a_warm_load: assert property (
    warm_reset_cmd_i |=> warm_reset_o && power_mode_o == 3'h1 && reset_flag_o && event_flags_o == 5'h00)
    else $error("warm reset did not reload");
  a_stream_first: assert property (
    reset_flag_o |-> comm_mode_o == 2'h0)
    else $error("left streaming before reset ack");
  a_no_recal: assert property (
    !hall_auto_recal_enable_i && !force_calibration_i && !calibration_active_o |=> !calibration_active_o)
    else $error("calibration started while disabled");
  a_cal_blocks: assert property (
    link_quiet ##0 (calibration_active_o && !comms_during_calibration_i && !comm_window_o) |=> !comm_window_o)
    else $error("window opened during calibration");
endmodule

bind spec_ctrl spec_chk chk_u (.*);

// file: verification/spec_host.sv
module spec_host (
  output logic link_clk_o,
  output logic link_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF_NS = 100;

  // both lines pulled up; the clock stands still between frames
  initial begin
    link_clk_o = 1'b1;
    link_data_o = 1'b1;
  end

  // start wakes a halted device and opens a window, stop closes it
  task automatic frame(input int bits);
    link_data_o = 1'b0;
    #HALF_NS;
    repeat (bits) begin
      link_clk_o = 1'b0;
      link_data_o = ~link_data_o;
      #HALF_NS;
      link_clk_o = 1'b1;
      #HALF_NS;
    end
    link_clk_o = 1'b0;
    link_data_o = 1'b0;
    #HALF_NS;
    link_clk_o = 1'b1;
    #HALF_NS;
    link_data_o = 1'b1;
    #HALF_NS;
  endtask
endmodule

// file: verification/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CPM = 8;
  localparam int LIMIT = 5000;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic link_clk_i, link_data_i;
  logic [2:0] power_mode_sel_i = 3'h1;
  logic [15:0] fast_period_ms_i = 16'h0001, normal_period_ms_i = 16'h0004, slow_period_ms_i = 16'h0008;
  logic [15:0] sleep_period_ms_i = 16'h0001;
  logic [4:0] event_mask_i = 5'h1f;
  logic event_mode_i = 1'b1, streaming_enable_i = 1'b1, core_oscillator_select_i = 1'b1;
  logic hall_auto_recal_enable_i = 1'b0, comms_during_calibration_i = 1'b0, touch_only_sleep_enable_i = 1'b0;
  logic warm_reset_cmd_i = 1'b0, ack_reset_i = 1'b0, force_calibration_i = 1'b0, rotation_i = 1'b0;
  logic touch_state_i = 1'b0, prox_state_i = 1'b0, hall_stationary_i = 1'b0, touch_dormant_i = 1'b0;
  logic hall_interval_change_i = 1'b0, hall_recal_needed_i = 1'b0;
  logic [2:0] power_mode_o;
  logic [1:0] comm_mode_o;
  logic [4:0] event_flags_o;
  logic hall_measure_o, touch_measure_o, comm_window_o, reset_flag_o;
  logic calibration_active_o, core_oscillator_select_o, warm_reset_o;
  int num_errors = 0, compares = 0, cycles = 0;

  spec_ctrl #(.CYCLES_PER_MS(CPM), .CAL_MS(2)) dut_u (.*);
  spec_host host_u (.link_clk_o(link_clk_i), .link_data_o(link_data_i));

  always #12.5 sys_clk_i = ~sys_clk_i;

  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // sample a little after the edge so the design's updates have landed
  task automatic look(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic wait_touch(output int n);
    n = 0;
    while (touch_measure_o !== 1'b1 && n < 64) begin
      look(1);
      n++;
    end
  endtask

  task automatic count_pulses(input int n, output int h, output int t);
    h = 0;
    t = 0;
    repeat (n) begin
      look(1);
      h += int'(hall_measure_o === 1'b1);
      t += int'(touch_measure_o === 1'b1);
    end
  endtask

  task automatic t_stream();
    int n;
    wait_touch(n);
    host_u.frame(0);
    look(4);
    chk(8'(comm_window_o), 8'h00, "stop closes window");
    wait_touch(n);
    while (comm_window_o !== 1'b1 && n < 70) begin
      look(1);
      n++;
    end
    chk(8'(comm_window_o), 8'h01, "stream window after cycle");
    look(1);
    wait_touch(n);
    chk(8'(n + 1), 8'(4 * CPM), "normal report period");
    chk(8'(hall_measure_o), 8'h01, "hall measured in cycle");
  endtask

  task automatic t_ack();
    step(1);
    ack_reset_i <= 1'b1;
    step(1);
    ack_reset_i <= 1'b0;
    look(2);
    chk(8'(reset_flag_o), 8'h00, "reset flag cleared");
    chk(8'(comm_mode_o), 8'h01, "event mode after ack");
  endtask

  task automatic t_mask();
    step(1);
    event_mask_i <= 5'h00;
    look(1);
    host_u.frame(0);
    look(6);
    step(1);
    touch_state_i <= 1'b1;
    look(20);
    chk(8'(event_flags_o[2]), 8'h01, "touch flag while masked");
    chk(8'(comm_window_o), 8'h00, "masked event opens no window");
    step(1);
    event_mask_i <= 5'h04;
    look(3);
    chk(8'(comm_window_o), 8'h01, "unmasked touch opens window");
    host_u.frame(0);
    look(6);
    chk(8'(event_flags_o), 8'h00, "flags cleared on read");
  endtask

  task automatic t_auto();
    int h, t;
    step(1);
    touch_state_i <= 1'b0;
    power_mode_sel_i <= 3'h5;
    rotation_i <= 1'b1;
    look(3);
    chk(8'(power_mode_o), 8'h00, "rotation selects fast-track");
    chk(8'(event_flags_o[0]), 8'h01, "mode change flag");
    step(1);
    rotation_i <= 1'b0;
    touch_dormant_i <= 1'b1;
    look(6);
    chk(8'(power_mode_o), 8'h01, "normal after fast-track");
    step(1);
    hall_stationary_i <= 1'b1;
    look(10);
    chk(8'(power_mode_o), 8'h02, "slow, sleep not enabled");
    step(1);
    touch_only_sleep_enable_i <= 1'b1;
    look(3);
    chk(8'(power_mode_o), 8'h03, "sleep when enabled");
    count_pulses(24, h, t);
    chk(8'(h), 8'h00, "no hall in sleep");
    chk(8'(t > 0), 8'h01, "touch sampled in sleep");
    step(1);
    touch_state_i <= 1'b1;
    look(3);
    chk(8'(power_mode_o), 8'h01, "touch returns to normal");
    step(1);
    power_mode_sel_i <= 3'h1;
    touch_state_i <= 1'b0;
    hall_stationary_i <= 1'b0;
    touch_dormant_i <= 1'b0;
  endtask

  task automatic t_halt();
    int h, t;
    step(1);
    power_mode_sel_i <= 3'h4;
    look(3);
    chk(8'(power_mode_o), 8'h04, "halt selected");
    count_pulses(70, h, t);
    chk(8'(h + t), 8'h00, "no sensing in halt");
    host_u.frame(0);
    look(4);
    chk(8'(power_mode_o), 8'h01, "start wakes from halt");
    step(1);
    power_mode_sel_i <= 3'h1;
  endtask

  task automatic t_warm();
    step(1);
    core_oscillator_select_i <= 1'b0;
    look(2);
    chk(8'(core_oscillator_select_o), 8'h00, "slow oscillator chosen");
    step(1);
    warm_reset_cmd_i <= 1'b1;
    step(1);
    warm_reset_cmd_i <= 1'b0;
    #1;
    chk(8'(warm_reset_o), 8'h01, "warm reset pulse");
    chk(8'(reset_flag_o), 8'h01, "reset flag after warm reset");
    chk(8'(core_oscillator_select_o), 8'h01, "oscillator back to default");
    step(1);
    core_oscillator_select_i <= 1'b1;
  endtask

  task automatic t_cal();
    int n;
    step(1);
    hall_auto_recal_enable_i <= 1'b1;
    hall_recal_needed_i <= 1'b1;
    step(1);
    hall_recal_needed_i <= 1'b0;
    look(1);
    chk(8'(calibration_active_o), 8'h01, "auto recalibration started");
    n = 0;
    while (calibration_active_o !== 1'b0 && n < 40) begin
      look(1);
      n++;
    end
    chk(8'(event_flags_o[1]), 8'h01, "calibration flag");
    step(1);
    hall_auto_recal_enable_i <= 1'b0;
    hall_recal_needed_i <= 1'b1;
    look(4);
    chk(8'(calibration_active_o), 8'h00, "no recalibration when disabled");
  endtask

  initial begin
    step(12);
    rst_i <= 1'b0;
    look(1);
    chk(8'(power_mode_o), 8'h01, "reset mode normal");
    chk(8'(reset_flag_o), 8'h01, "reset flag set");
    chk(8'(core_oscillator_select_o), 8'h01, "reset oscillator");
    t_stream();
    t_ack();
    t_mask();
    t_auto();
    t_halt();
    t_warm();
    t_ack();
    t_cal();
    stop_test();
  end
endmodule
